// *** core/hbi_cfg.svh ***
// constants of the host bus interface: offsets, resets, timing
`ifndef HBI_CFG_SVH
`define HBI_CFG_SVH
// register select codes
`define HBI_REG_DIAGNOSTIC_STATUS_REG 3'h0
`define HBI_REG_CONFIG 3'h1
`define HBI_REG_PTR_HI 3'h2
`define HBI_REG_PTR_LO 3'h3
`define HBI_REG_DATA 3'h4
`define HBI_REG_NEXT_ID 3'h5
// pointer high byte fields
`define HBI_PHI_AUTO_INC 7
`define HBI_PHI_READ_DIR 6
`define HBI_PHI_ADDR_MSB 2
// config register field
`define HBI_CFG_FAST_READ 0
// reset values
`define HBI_RST_BYTE 8'h00
`define HBI_RST_PTR 11'h000
// buffer ram
`define HBI_RAM_AW 11
`define HBI_RAM_WORDS 2048
// read delays: figures in ns, counts rounded up at the clock period
`define HBI_CLK_NS 4
`define HBI_RD1_DLY_NS 15
`define HBI_RD2_DLY_NS 10
`define HBI_RD1_CYC ((`HBI_RD1_DLY_NS + `HBI_CLK_NS - 1) / `HBI_CLK_NS)
`define HBI_RD2_CYC ((`HBI_RD2_DLY_NS + `HBI_CLK_NS - 1) / `HBI_CLK_NS)
`define HBI_CNT_W 4
`endif

// *** core/hbi_pkg.sv ***
// types of the host bus interface
package hbi_pkg;
  // detection progress, gray coded
  typedef enum logic [1:0] {
    HBI_DET_UNKNOWN = 2'b00,
    HBI_DET_DECIDED = 2'b01,
    HBI_DET_LOCKED = 2'b11
  } hbi_det_t;
  // strobe style
  typedef enum logic {
    HBI_STROBE_SEP = 1'b0,
    HBI_STROBE_DS = 1'b1
  } hbi_style_t;
endpackage

// *** core/hbi_rd_if.sv ***
// internal read path between the port and its read pulse generator
`timescale 1ns/1ps
interface hbi_rd_if;
  logic rd_int; // internal read, level
  logic cs; // chip select seen by the read path
  logic [2:0] addr; // register select seen by the read path
  logic diagnostic_status_reg_clr; // clear pulse for the diagnostic register
  logic data_rd; // data register read pulse, steps the pointer under auto-increment
  logic nid_rd; // next id read pulse
  modport src (output rd_int, output cs, output addr,
    input diagnostic_status_reg_clr, input data_rd, input nid_rd);
  modport gen (input rd_int, input cs, input addr,
    output diagnostic_status_reg_clr, output data_rd, output nid_rd);
endinterface

// *** core/hbi_read_pulse.sv ***
// read pulse generator: one pulse per internal read start at the diagnostic, data or next id register
`timescale 1ns/1ps
`include "hbi_cfg.svh"
module hbi_read_pulse (
  input wire logic mclk,
  input wire logic rst_n,
  hbi_rd_if.gen rp
);
  logic rd_q; // previous internal read level
  logic start; // rising internal read with select
  logic hit_diagnostic_status_reg;
  logic hit_data;
  logic hit_nid;
  logic diagnostic_status_reg_q;
  logic data_q;
  logic nid_q;

  assign start = rp.rd_int && !rd_q && rp.cs;
  assign hit_diagnostic_status_reg = start && (rp.addr == `HBI_REG_DIAGNOSTIC_STATUS_REG);
  assign hit_data = start && (rp.addr == `HBI_REG_DATA);
  assign hit_nid = start && (rp.addr == `HBI_REG_NEXT_ID);

  // pulse registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      diagnostic_status_reg_q <= 1'b0;
      data_q <= 1'b0;
      nid_q <= 1'b0;
    end else begin
      rd_q <= rp.rd_int;
      diagnostic_status_reg_q <= hit_diagnostic_status_reg;
      data_q <= hit_data;
      nid_q <= hit_nid;
    end
  end

  assign rp.diagnostic_status_reg_clr = diagnostic_status_reg_q;
  assign rp.data_rd = data_q;
  assign rp.nid_rd = nid_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  pulse_single_a: assert property (rp.diagnostic_status_reg_clr |=> !rp.diagnostic_status_reg_clr)
    else $error("diagnostic_status_reg clear pulse longer than one cycle");
  pulse_cause_a: assert property (rp.data_rd |-> $past(rp.rd_int) && !$past(rp.rd_int, 2))
    else $error("data read pulse without read start");
endmodule

// *** core/hbi_host_port.sv ***
// host parallel port: bus detection, registers, pointer access to ram
`timescale 1ns/1ps
`include "hbi_cfg.svh"
//////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////
module hbi_host_port (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic chip_select_low,
  input wire logic read_strobe_low, // read, or direction (high = read)
  input wire logic write_strobe_low,
  input wire logic data_strobe_low,
  input wire logic address_latch_enable, // multiplexed bus only
  input wire logic [2:0] register_select_lines,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_low,
  input wire logic [7:0] diagnostic_status_reg_set, // event bits into diagnostic register
  input wire logic [7:0] next_node_id,
  output logic next_id_read_pulse,
  input wire logic core_ram_req,
  input wire logic core_ram_we,
  input wire logic [10:0] core_ram_addr,
  input wire logic [7:0] core_ram_wdata,
  output logic core_ram_gnt,
  output logic [7:0] core_ram_rdata,
  output logic strobe_style_ds,
  output logic bus_multiplexed,
  output logic decisions_locked,
  output logic fast_read_timing_enable
);
  //////////////////////////////////////////////////////////////////////
  // state
  hbi_pkg::hbi_det_t det_q; // strobe style detection state
  hbi_pkg::hbi_style_t style_q; // chosen strobe style
  logic mux_q; // multiplexed bus flag
  logic bus_fixed_q; // bus type decided
  logic fast_q; // fast read timing bit
  logic [2:0] alat_q; // latched address in multiplexed mode
  logic [7:0] diagnostic_status_reg_q; // diagnostic status
  logic [7:0] data_q; // data register
  logic ai_q; // auto-increment enable
  logic rdir_q; // pointer loaded for reads
  logic [10:0] ptr_q; // ram pointer
  logic fetch_q; // prefetch pending
  logic store_q; // store pending
  logic wr_q; // previous write level
  logic [`HBI_CNT_W-1:0] cnt_q; // read delay counter
  logic cs_s_q; // sampled select
  logic [2:0] addr_s_q; // sampled address
  logic [7:0] dout_q; // data output flop
  logic [7:0] core_rd_q; // core read data
  logic [7:0] ram_q [0:`HBI_RAM_WORDS-1]; // buffer ram
  hbi_rd_if rp ();

  //////////////////////////////////////////////////////////////////////
  // strobe decode
  logic cs; // select active
  logic ds; // data strobe active
  logic rd; // read active, undelayed
  logic wr; // write active
  logic [2:0] addr; // current register select
  logic lowest_address_line;
  // both styles feed one read path
  assign cs = !chip_select_low;
  assign ds = !data_strobe_low;
  assign rd = (style_q == hbi_pkg::HBI_STROBE_DS) ? (ds && read_strobe_low) : !read_strobe_low;
  assign wr = (style_q == hbi_pkg::HBI_STROBE_DS) ? (ds && !read_strobe_low)
    : !write_strobe_low;
  assign lowest_address_line = register_select_lines[0];
  assign addr = mux_q ? alat_q : register_select_lines;

  //////////////////////////////////////////////////////////////////////
  // detection
  logic sep_seen; // separate write strobe used
  logic ds_seen; // data strobe used for a write
  logic lock_now; // select and read together
  logic a0_act; // address line zero high in an access
  // first external write reveals the style
  assign sep_seen = !write_strobe_low;
  assign ds_seen = ds && !read_strobe_low && write_strobe_low;
  assign lock_now = cs && rd;
  // odd access shows address line zero
  assign a0_act = cs && (rd || wr) && lowest_address_line;

  // strobe style state machine
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      det_q <= hbi_pkg::HBI_DET_UNKNOWN;
      style_q <= hbi_pkg::HBI_STROBE_SEP;
    end else begin
      case (det_q)
        hbi_pkg::HBI_DET_UNKNOWN: begin
          if (lock_now) begin
            det_q <= hbi_pkg::HBI_DET_LOCKED;
          end else if (sep_seen) begin
            det_q <= hbi_pkg::HBI_DET_DECIDED;
          end else if (ds_seen) begin
            det_q <= hbi_pkg::HBI_DET_DECIDED;
            style_q <= hbi_pkg::HBI_STROBE_DS;
          end
        end
        hbi_pkg::HBI_DET_DECIDED: begin
          if (lock_now) begin
            det_q <= hbi_pkg::HBI_DET_LOCKED;
          end
        end
        default: begin
          det_q <= hbi_pkg::HBI_DET_LOCKED;
        end
      endcase
    end
  end

  // bus type flag
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mux_q <= 1'b1;
      bus_fixed_q <= 1'b0;
    end else if (!bus_fixed_q && (det_q != hbi_pkg::HBI_DET_LOCKED)) begin
      if (a0_act) begin
        mux_q <= 1'b0;
        bus_fixed_q <= 1'b1;
      end else if (lock_now) begin
        bus_fixed_q <= 1'b1;
      end
    end
  end

  // address latch for multiplexed bus
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alat_q <= 3'h0;
    end else if (address_latch_enable) begin
      alat_q <= data_in[2:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // fast read delay and sampling
  logic rd1; // first delayed read
  logic rd2; // second delayed read
  logic rd1_fall; // first delayed read just asserted
  logic [`HBI_CNT_W-1:0] rd1_n;
  logic [`HBI_CNT_W-1:0] rd2_n;
  assign rd1_n = `HBI_CNT_W'(`HBI_RD1_CYC);
  assign rd2_n = `HBI_CNT_W'(`HBI_RD1_CYC + `HBI_RD2_CYC);
  // delays on assertion, none on release
  assign rd1 = rd && (cnt_q >= rd1_n);
  assign rd2 = rd && (cnt_q >= rd2_n);
  assign rd1_fall = rd && (cnt_q == rd1_n);

  // delay counter, cleared at the first clock edge after read releases
  always_ff @(posedge mclk) begin
    if (!rst_n || !rd) begin
      cnt_q <= `HBI_CNT_W'(0);
    end else if (cnt_q != rd2_n) begin
      cnt_q <= cnt_q + `HBI_CNT_W'(1);
    end
  end

  // sample select and address at the first delayed edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_s_q <= 1'b0;
      addr_s_q <= 3'h0;
    end else if (rd1_fall) begin
      cs_s_q <= cs;
      addr_s_q <= addr;
    end
  end

  // timing bit picks the read path
  assign rp.rd_int = fast_q ? (rd2 && rd1) : rd;
  assign rp.cs = fast_q ? cs_s_q : cs;
  assign rp.addr = fast_q ? addr_s_q : addr;

  hbi_read_pulse u_pulse (
    .mclk(mclk),
    .rst_n(rst_n),
    .rp(rp)
  );

  //////////////////////////////////////////////////////////////////////
  // host writes, taken on write assertion with current address
  logic wr_take; // write start this cycle
  logic w_cfg;
  logic w_phi;
  logic w_plo;
  logic w_data;
  assign wr_take = wr && !wr_q && cs;
  assign w_cfg = wr_take && (addr == `HBI_REG_CONFIG);
  assign w_phi = wr_take && (addr == `HBI_REG_PTR_HI);
  assign w_plo = wr_take && (addr == `HBI_REG_PTR_LO);
  assign w_data = wr_take && (addr == `HBI_REG_DATA);

  // config and write edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      fast_q <= 1'b0;
    end else begin
      wr_q <= wr;
      if (w_cfg) begin
        fast_q <= data_in[`HBI_CFG_FAST_READ];
      end
    end
  end

  // diagnostic register; a new event beats the clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      diagnostic_status_reg_q <= `HBI_RST_BYTE;
    end else begin
      diagnostic_status_reg_q <= (rp.diagnostic_status_reg_clr ? `HBI_RST_BYTE : diagnostic_status_reg_q) | diagnostic_status_reg_set;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pointer, data register and ram
  logic host_busy; // host owns the ram this cycle
  logic [7:0] fetch_byte; // ram byte at the pointer
  logic ptr_step; // advance pointer
  assign host_busy = fetch_q || store_q;
  assign fetch_byte = ram_q[ptr_q];
  assign ptr_step = ai_q && (store_q || rp.data_rd);

  // pointer and flags
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ai_q <= 1'b0;
      rdir_q <= 1'b0;
      ptr_q <= `HBI_RST_PTR;
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= w_plo && rdir_q;
      if (w_phi) begin
        ai_q <= data_in[`HBI_PHI_AUTO_INC];
        rdir_q <= data_in[`HBI_PHI_READ_DIR];
        ptr_q[10:8] <= data_in[`HBI_PHI_ADDR_MSB:0];
      end else if (w_plo) begin
        ptr_q[7:0] <= data_in;
      end else if (ptr_step) begin
        ptr_q <= ptr_q + `HBI_RAM_AW'(1);
      end
    end
  end

  // data register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_q <= `HBI_RST_BYTE;
      store_q <= 1'b0;
    end else begin
      store_q <= w_data;
      if (w_data) begin
        data_q <= data_in;
      end else if (fetch_q) begin
        data_q <= fetch_byte;
      end
      // a data read leaves data_q alone
    end
  end

  // ram: host store first, core otherwise
  always_ff @(posedge mclk) begin
    if (store_q) begin
      ram_q[ptr_q] <= data_q;
    end else if (core_ram_gnt && core_ram_we) begin
      ram_q[core_ram_addr] <= core_ram_wdata;
    end
  end

  // core read data
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      core_rd_q <= `HBI_RST_BYTE;
    end else if (core_ram_gnt && !core_ram_we) begin
      core_rd_q <= ram_q[core_ram_addr];
    end
  end

  assign core_ram_gnt = core_ram_req && !host_busy;
  assign core_ram_rdata = core_rd_q;

  //////////////////////////////////////////////////////////////////////
  // read data path
  logic [7:0] rd_mux;
  logic [7:0] phi_val;
  assign phi_val = {ai_q, rdir_q, 3'h0, ptr_q[10:8]};
  assign rd_mux = (addr == `HBI_REG_DIAGNOSTIC_STATUS_REG) ? diagnostic_status_reg_q
    : (addr == `HBI_REG_CONFIG) ? {7'h00, fast_q}
    : (addr == `HBI_REG_PTR_HI) ? phi_val
    : (addr == `HBI_REG_PTR_LO) ? ptr_q[7:0]
    : (addr == `HBI_REG_DATA) ? data_q
    : (addr == `HBI_REG_NEXT_ID) ? next_node_id
    : 8'h00;

  // output flop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dout_q <= `HBI_RST_BYTE;
    end else begin
      dout_q <= rd_mux;
    end
  end

  assign data_out = dout_q;
  assign data_oe_low = !(cs && rd);
  assign next_id_read_pulse = rp.nid_rd;
  assign strobe_style_ds = (style_q == hbi_pkg::HBI_STROBE_DS);
  assign bus_multiplexed = mux_q;
  assign decisions_locked = (det_q == hbi_pkg::HBI_DET_LOCKED);
  assign fast_read_timing_enable = fast_q;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  style_default_a: assert property (det_q == hbi_pkg::HBI_DET_UNKNOWN |-> !strobe_style_ds)
    else $error("style left default before detection");
  style_hold_a: assert property (det_q != hbi_pkg::HBI_DET_UNKNOWN |=> $stable(style_q))
    else $error("strobe style changed after decision");
  bus_fixed_a: assert property (!mux_q |=> !mux_q)
    else $error("bus type changed back");
  lock_now_a: assert property (cs && rd |=> decisions_locked)
    else $error("select plus read did not lock");
  prefetch_a: assert property (w_plo && rdir_q |=> ##2 data_q == $past(fetch_byte))
    else $error("prefetch did not load data register");
  no_refetch_a: assert property (rp.data_rd && !fetch_q && !w_data |=> $stable(data_q))
    else $error("data read changed data register");
  store_path_a: assert property (w_data |=> store_q && data_q == $past(data_in))
    else $error("data write not captured");
  diagnostic_status_reg_clear_a: assert property (rp.diagnostic_status_reg_clr && diagnostic_status_reg_set == 8'h00 |=> diagnostic_status_reg_q == 8'h00)
    else $error("diagnostic_status_reg not cleared by read");
  fast_delay_a: assert property (fast_q && rp.rd_int |-> cnt_q >= rd2_n && rd)
    else $error("fast internal read too early");
  no_wait_a: assert property (core_ram_gnt |-> !host_busy)
    else $error("core granted during host access");
  reset_dflt_a: assert property (@(posedge mclk) !rst_n |=> mux_q && !fast_q
    && det_q == hbi_pkg::HBI_DET_UNKNOWN)
    else $error("reset defaults not restored");

  lock_c: cover property (det_q == hbi_pkg::HBI_DET_DECIDED ##1 decisions_locked);
  fetch_c: cover property (fetch_q);
  fast_rd_c: cover property (fast_q && rp.data_rd);
endmodule

// *** sim/hbi_host_model.sv ***
// host bus master model: separate or direction strobes, plain or multiplexed
`timescale 1ns/1ps
module hbi_host_model (
  input wire logic mclk,
  output logic chip_select_low,
  output logic read_strobe_low,
  output logic write_strobe_low,
  output logic data_strobe_low,
  output logic address_latch_enable,
  output logic [2:0] register_select_lines,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_low
);
  logic ds_mode; // direction plus data strobe style
  logic mux_mode; // address carried on the data lines
  logic [7:0] rd_data; // byte taken by the last read
  logic rd_oe; // output enable seen in the last read
  //////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    ds_mode = 1'b0;
    mux_mode = 1'b0;
    chip_select_low = 1'b1;
    read_strobe_low = 1'b1;
    write_strobe_low = 1'b1;
    data_strobe_low = 1'b1;
    address_latch_enable = 1'b0;
    register_select_lines = 3'h0;
    data_in = 8'hFF;
  end
  // release strobes; the data lines show a changed value
  task automatic idle(input logic [7:0] d);
    chip_select_low <= 1'b1;
    read_strobe_low <= 1'b1;
    write_strobe_low <= 1'b1;
    data_strobe_low <= 1'b1;
    data_in <= d;
  endtask
  // address phase, latched from the data lines when multiplexed
  task automatic addr_phase(input logic [2:0] a);
    @(posedge mclk);
    if (mux_mode) begin
      // address line zero stays low on a multiplexed bus
      register_select_lines <= 3'h0;
      address_latch_enable <= 1'b1;
      data_in <= {5'h00, a};
      @(posedge mclk);
      address_latch_enable <= 1'b0;
      data_in <= {5'h1F, ~a};
    end else begin
      register_select_lines <= a;
    end
  endtask
  // write strobe for one sampling edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic sel);
    addr_phase(a);
    @(posedge mclk);
    chip_select_low <= ~sel;
    data_in <= d;
    if (ds_mode) begin
      read_strobe_low <= 1'b0;
      data_strobe_low <= 1'b0;
    end else begin
      write_strobe_low <= 1'b0;
    end
    @(posedge mclk);
    idle(~d);
  endtask
  // read held for hold edges, data taken early
  task automatic rd(input logic [2:0] a, input int hold);
    addr_phase(a);
    @(posedge mclk);
    chip_select_low <= 1'b0;
    if (ds_mode) begin
      data_strobe_low <= 1'b0;
    end else begin
      read_strobe_low <= 1'b0;
    end
    repeat (2) @(posedge mclk);
    rd_data = data_out;
    rd_oe = data_oe_low;
    repeat (hold - 2) @(posedge mclk);
    idle(~data_in);
  endtask
endmodule

// *** sim/hbi_host_port_test.sv ***
// self-checking bench of the host port
`timescale 1ns/1ps
module hbi_host_port_test;
  logic mclk, rst_n, cs_n, rd_n, wr_n, ds_n, ale, oe_n;
  logic [2:0] rsel;
  logic [7:0] din, dout, diagnostic_status_reg_set, rdata, wdata;
  logic req, we, gnt, nid_p, sty, mux, lck, fst;
  logic [10:0] caddr;
  int err_count, comparisons, pulse_count, p0;
  //////////////////////////////////////////////////////////////////////
  hbi_host_model u_hbi_host_model (.mclk(mclk), .chip_select_low(cs_n),
    .read_strobe_low(rd_n), .write_strobe_low(wr_n), .data_strobe_low(ds_n),
    .address_latch_enable(ale), .register_select_lines(rsel), .data_in(din),
    .data_out(dout), .data_oe_low(oe_n));
  hbi_host_port u_hbi_host_port (.mclk(mclk), .rst_n(rst_n), .chip_select_low(cs_n),
    .read_strobe_low(rd_n), .write_strobe_low(wr_n), .data_strobe_low(ds_n),
    .address_latch_enable(ale), .register_select_lines(rsel), .data_in(din),
    .data_out(dout), .data_oe_low(oe_n), .diagnostic_status_reg_set(diagnostic_status_reg_set),
    .next_node_id(8'h2A), .next_id_read_pulse(nid_p), .core_ram_req(req),
    .core_ram_we(we), .core_ram_addr(caddr), .core_ram_wdata(wdata),
    .core_ram_gnt(gnt), .core_ram_rdata(rdata), .strobe_style_ds(sty),
    .bus_multiplexed(mux), .decisions_locked(lck), .fast_read_timing_enable(fst));
  //////////////////////////////////////////////////////////////////////
  // clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // count next id read pulses
  always @(posedge mclk) begin
    if (nid_p === 1'b1) begin
      pulse_count <= pulse_count + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // flags as {style, multiplexed, locked, fast}
  task automatic flags(input logic [3:0] exp);
    @(posedge mclk);
    check("flags", {4'h0, sty, mux, lck, fst}, {4'h0, exp});
  endtask
  // host read with data and drive enable checked
  task automatic rd_chk(input logic [2:0] a, input int hold, input logic [7:0] exp);
    p0 = pulse_count;
    u_hbi_host_model.rd(a, hold);
    repeat (4) @(posedge mclk);
    check("read", u_hbi_host_model.rd_data, exp);
    check("oe", {7'h00, u_hbi_host_model.rd_oe}, 8'h00);
  endtask
  // next id pulses since the last read
  task automatic pulses(input logic [7:0] exp);
    check("pulses", 8'(pulse_count - p0), exp);
  endtask
  // engine port access, bounded wait for grant
  task automatic core_op(input logic w, input logic [10:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    req <= 1'b1;
    we <= w;
    caddr <= a;
    wdata <= d;
    for (n = 0; n < 8; n++) begin
      @(posedge mclk);
      if (gnt === 1'b1) break;
    end
    if (n == 8) begin
      err_count++;
      end_of_test();
    end
    req <= 1'b0;
    @(posedge mclk);
  endtask
  // one diagnostic event cycle
  task automatic diagnostic_status_reg_event(input logic [7:0] v);
    @(posedge mclk);
    diagnostic_status_reg_set <= v;
    @(posedge mclk);
    diagnostic_status_reg_set <= 8'h00;
  endtask
  // counts and verdict
  task automatic end_of_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    err_count = 0;
    comparisons = 0;
    pulse_count = 0;
    rst_n = 1'b0;
    diagnostic_status_reg_set = 8'h00;
    req = 1'b0;
    we = 1'b0;
    caddr = 11'h000;
    wdata = 8'h00;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    flags(4'h4);
    check("dout", dout, 8'h00);
    $display("test reset done");
    u_hbi_host_model.wr(3'h1, 8'h00, 1'b1);
    flags(4'h0);
    rd_chk(3'h1, 4, 8'h00);
    flags(4'h2);
    u_hbi_host_model.ds_mode = 1'b1;
    u_hbi_host_model.wr(3'h2, 8'h00, 1'b1);
    u_hbi_host_model.ds_mode = 1'b0;
    flags(4'h2);
    $display("test detection done");
    u_hbi_host_model.wr(3'h2, 8'h81, 1'b1);
    u_hbi_host_model.wr(3'h3, 8'h10, 1'b1);
    u_hbi_host_model.wr(3'h4, 8'hA5, 1'b1);
    u_hbi_host_model.wr(3'h4, 8'h5A, 1'b1);
    u_hbi_host_model.wr(3'h4, 8'h3C, 1'b1);
    core_op(1'b0, 11'h110, 8'h00);
    check("core", rdata, 8'hA5);
    core_op(1'b0, 11'h112, 8'h00);
    check("core", rdata, 8'h3C);
    core_op(1'b1, 11'h120, 8'h77);
    u_hbi_host_model.wr(3'h2, 8'h41, 1'b1);
    u_hbi_host_model.wr(3'h3, 8'h11, 1'b1);
    rd_chk(3'h4, 4, 8'h5A);
    rd_chk(3'h4, 4, 8'h5A);
    u_hbi_host_model.wr(3'h3, 8'h20, 1'b1);
    rd_chk(3'h4, 4, 8'h77);
    u_hbi_host_model.wr(3'h2, 8'hC1, 1'b1);
    u_hbi_host_model.wr(3'h3, 8'h10, 1'b1);
    rd_chk(3'h4, 4, 8'hA5);
    rd_chk(3'h4, 4, 8'hA5);
    u_hbi_host_model.wr(3'h2, 8'h01, 1'b1);
    u_hbi_host_model.wr(3'h3, 8'h30, 1'b1);
    u_hbi_host_model.wr(3'h4, 8'h11, 1'b1);
    u_hbi_host_model.wr(3'h4, 8'h22, 1'b1);
    core_op(1'b0, 11'h130, 8'h00);
    check("core", rdata, 8'h22);
    $display("test ram done");
    diagnostic_status_reg_event(8'h81);
    u_hbi_host_model.wr(3'h0, 8'hFF, 1'b1);
    rd_chk(3'h0, 4, 8'h81);
    rd_chk(3'h0, 4, 8'h00);
    rd_chk(3'h5, 4, 8'h2A);
    pulses(8'h01);
    rd_chk(3'h6, 4, 8'h00);
    $display("test normal reads done");
    u_hbi_host_model.wr(3'h1, 8'h01, 1'b1);
    flags(4'h3);
    diagnostic_status_reg_event(8'h42);
    rd_chk(3'h0, 4, 8'h42);
    rd_chk(3'h0, 12, 8'h42);
    rd_chk(3'h0, 4, 8'h00);
    rd_chk(3'h5, 4, 8'h2A);
    pulses(8'h00);
    rd_chk(3'h5, 12, 8'h2A);
    pulses(8'h01);
    $display("test fast reads done");
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    flags(4'h4);
    u_hbi_host_model.ds_mode = 1'b1;
    u_hbi_host_model.mux_mode = 1'b1;
    u_hbi_host_model.wr(3'h1, 8'h01, 1'b0);
    flags(4'hC);
    u_hbi_host_model.wr(3'h1, 8'h01, 1'b1);
    flags(4'hD);
    rd_chk(3'h5, 12, 8'h2A);
    pulses(8'h01);
    flags(4'hF);
    u_hbi_host_model.ds_mode = 1'b0;
    u_hbi_host_model.wr(3'h0, 8'h00, 1'b0);
    flags(4'hF);
    $display("test direction strobe done");
    end_of_test();
  end
endmodule
